// File: logic/bbo_consts.svh
// Constants for the branch and bit-op execution block
`ifndef BBO_CONSTS_SVH
`define BBO_CONSTS_SVH
`define BBO_OP_JUMP     5'h1a
`define BBO_OP_SET      4'h8
`define BBO_OP_SKIP_LO  4'hb
`define BBO_OP_SKIP_HI  4'ha
`define BBO_IDX_LIMIT   8'h5f
`define BBO_ACC_SPLIT   8'h60
`define BBO_ACC_HI_BANK 4'hf
`define BBO_PC_STEP     21'h000002
`define BBO_PC_RESET    21'h000000
`define BBO_PHASE_LAST  2'h3
`define BBO_F_OP5       15:11
`define BBO_F_OP4       15:12
`define BBO_F_BIT       11:9
`define BBO_F_ACC       8
`define BBO_F_REG       7:0
`define BBO_F_OFFS      10:0
`define BBO_F_SIGN      10
`define BBO_F_BANK      11:8
`define BBO_SEXT_W      9
`define BBO_BIT_ONE     8'h01
`define BBO_ACC_LO_BANK 4'h0
`endif

// File: logic/bbo_pkg.sv
// Types for the branch and bit-op execution block
package bbo_pkg;
  typedef enum logic [1:0] {
    BBO_Q1 = 2'b00,
    BBO_Q2 = 2'b01,
    BBO_Q3 = 2'b10,
    BBO_Q4 = 2'b11
  } bbo_phase_e;
  typedef logic [20:0] bbo_pc_t;
  typedef logic [11:0] bbo_addr_t;
endpackage

// File: logic/bbo_addr_gen.sv
// Data-memory address former for bit-oriented instructions
module bbo_addr_gen (
  input  wire logic [7:0]    reg_addr,
  input  wire logic          access_flag,
  input  wire logic [3:0]    bank_select_reg,
  input  wire logic          ext_set_en,
  input  wire logic [11:0]   index_base,
  output bbo_pkg::bbo_addr_t mem_addr,
  output logic               indexed
);
  import bbo_pkg::*;
`include "bbo_consts.svh"
  always_comb begin
    indexed  = 1'b0;
    mem_addr = {bank_select_reg, reg_addr};
    if (!access_flag) begin
      if (ext_set_en && reg_addr <= `BBO_IDX_LIMIT) begin
        indexed  = 1'b1;
        mem_addr = index_base + {4'h0, reg_addr};
      end else if (reg_addr < `BBO_ACC_SPLIT) begin
        mem_addr = {`BBO_ACC_LO_BANK, reg_addr};
      end else begin
        mem_addr = {`BBO_ACC_HI_BANK, reg_addr};
      end
    end
  end
endmodule

// File: logic/bbo_exec.sv
// Branch and bit-op executor, one instruction per four-phase cycle
// Behaviour
// - Relative jump target is the incremented PC plus twice the signed offset.
// - Relative jump is one word, two cycles, the second a no-operation refill.
// - Relative jump is decoded from top bits 11010 with an 11-bit signed offset.
// - Bit set forces the indexed bit of the addressed register high, others kept.
// - Access flag 0 addresses the access bank.
// - Access flag 1 forms the address from the bank select register and f.
// - Flag 0 with extended set on treats f up to 95 as an indexed literal offset.
// - Top nibble 1011 skips when the bit is low, 1010 when it is high; no flags.
module bbo_exec (
  input  wire logic          clk_sys,
  input  wire logic          reset_n,
  input  wire logic [15:0]   instr_word,
  input  wire logic [3:0]    bank_select_reg,
  input  wire logic          ext_set_en,
  input  wire logic [11:0]   index_base,
  input  wire logic [7:0]    mem_rdata,
  output bbo_pkg::bbo_phase_e phase,
  output bbo_pkg::bbo_pc_t    pc,
  output bbo_pkg::bbo_addr_t  mem_addr,
  output logic                mem_rd,
  output logic                mem_wr,
  output logic [7:0]          mem_wdata,
  output logic                skip_next,
  output logic                flush
);
  import bbo_pkg::*;
`include "bbo_consts.svh"

  typedef struct packed {
    bbo_phase_e  phase;
    bbo_pc_t     pc;
    logic [15:0] ir;
    logic        refill;
    logic        skip_pend;
    bbo_addr_t   mem_addr;
    logic        mem_rd;
    logic        mem_wr;
    logic [7:0]  data;
    logic        skip_next;
    logic        flush;
  } bbo_state_s;

  bbo_state_s st;
  bbo_state_s next_st;
  bbo_addr_t  ea;
  logic       ea_indexed;
  logic       is_jump;
  logic       is_set;
  logic       is_skip_lo;
  logic       is_skip_hi;
  logic       bit_val;
  bbo_pc_t    jump_target;

  bbo_addr_gen u_bbo_addr_gen (
    .reg_addr        (st.ir[`BBO_F_REG]),
    .access_flag     (st.ir[`BBO_F_ACC]),
    .bank_select_reg (bank_select_reg),
    .ext_set_en      (ext_set_en),
    .index_base      (index_base),
    .mem_addr        (ea),
    .indexed         (ea_indexed)
  );

  // Refill cycle decodes nothing; the fetched word is discarded
  assign is_jump    = !st.refill && st.ir[`BBO_F_OP5] == `BBO_OP_JUMP;
  assign is_set     = !st.refill && st.ir[`BBO_F_OP4] == `BBO_OP_SET;
  assign is_skip_lo = !st.refill && st.ir[`BBO_F_OP4] == `BBO_OP_SKIP_LO;
  assign is_skip_hi = !st.refill && st.ir[`BBO_F_OP4] == `BBO_OP_SKIP_HI;
  assign bit_val    = mem_rdata[st.ir[`BBO_F_BIT]];
  // PC already advanced past the jump word at fetch
  assign jump_target = st.pc + {{`BBO_SEXT_W{st.ir[`BBO_F_SIGN]}},
                                st.ir[`BBO_F_OFFS], 1'b0};

  always_comb begin
    next_st        = st;
    next_st.mem_rd = 1'b0;
    next_st.mem_wr = 1'b0;
    next_st.flush  = 1'b0;
    unique case (st.phase)
      BBO_Q1: begin
        next_st.phase     = BBO_Q2;
        next_st.ir        = instr_word;
        next_st.pc        = st.pc + `BBO_PC_STEP;
        next_st.skip_next = 1'b0;
      end
      BBO_Q2: begin
        next_st.phase = BBO_Q3;
        if (is_set || is_skip_lo || is_skip_hi) begin
          next_st.mem_addr = ea;
          next_st.mem_rd   = 1'b1;
        end
      end
      BBO_Q3: begin
        next_st.phase = BBO_Q4;
        if (is_set) begin
          next_st.data = mem_rdata | (`BBO_BIT_ONE << st.ir[`BBO_F_BIT]);
        end
        if (is_skip_lo) begin
          next_st.skip_pend = !bit_val;
        end else if (is_skip_hi) begin
          next_st.skip_pend = bit_val;
        end else begin
          next_st.skip_pend = 1'b0;
        end
      end
      BBO_Q4: begin
        next_st.phase  = BBO_Q1;
        next_st.refill = 1'b0;
        if (is_jump) begin
          next_st.pc     = jump_target;
          next_st.refill = 1'b1;
          next_st.flush  = 1'b1;
        end
        if (is_set) begin
          next_st.mem_wr = 1'b1;
        end
        next_st.skip_next = st.skip_pend;
      end
    endcase
    if (!reset_n) begin
      next_st          = '0;
      next_st.phase    = BBO_Q1;
      next_st.pc       = `BBO_PC_RESET;
    end
  end

  always_ff @(posedge clk_sys) begin
    st <= next_st;
  end

  assign phase     = st.phase;
  assign pc        = st.pc;
  assign mem_addr  = st.mem_addr;
  assign mem_rd    = st.mem_rd;
  assign mem_wr    = st.mem_wr;
  assign mem_wdata = st.data;
  assign skip_next = st.skip_next;
  assign flush     = st.flush;

  property p_jump_target;
    @(posedge clk_sys) disable iff (!reset_n)
      (st.phase == BBO_Q4 && is_jump) |=> pc == $past(jump_target);
  endproperty
  a_jump_target: assert property (p_jump_target) else $error("jump target wrong");

  property p_jump_refill;
    @(posedge clk_sys) disable iff (!reset_n)
      (st.phase == BBO_Q4 && is_jump) |=> flush ##1 (!mem_rd && !mem_wr) [*4];
  endproperty
  a_jump_refill: assert property (p_jump_refill) else $error("refill not idle");

  property p_jump_decode;
    @(posedge clk_sys) disable iff (!reset_n)
      (st.phase == BBO_Q4 && !st.refill && st.ir[`BBO_F_OP5] != `BBO_OP_JUMP) |=> !flush;
  endproperty
  a_jump_decode: assert property (p_jump_decode) else $error("false jump");

  property p_set_data;
    @(posedge clk_sys) disable iff (!reset_n)
      (st.phase == BBO_Q3 && is_set) |=> mem_wdata[$past(st.ir[`BBO_F_BIT])] ##1 mem_wr;
  endproperty
  a_set_data: assert property (p_set_data) else $error("bit not set");

  property p_access_bank;
    @(posedge clk_sys) disable iff (!reset_n)
      (st.phase == BBO_Q2 && is_set && !st.ir[`BBO_F_ACC] && !ext_set_en)
        |=> mem_addr[`BBO_F_BANK] == `BBO_ACC_LO_BANK
            || mem_addr[`BBO_F_BANK] == `BBO_ACC_HI_BANK;
  endproperty
  a_access_bank: assert property (p_access_bank) else $error("access bank wrong");

  property p_banked;
    @(posedge clk_sys) disable iff (!reset_n)
      (st.phase == BBO_Q2 && is_set && st.ir[`BBO_F_ACC])
        |=> mem_addr == {$past(bank_select_reg), $past(st.ir[`BBO_F_REG])};
  endproperty
  a_banked: assert property (p_banked) else $error("banked address wrong");

  property p_indexed;
    @(posedge clk_sys) disable iff (!reset_n)
      (st.phase == BBO_Q2 && is_set && !st.ir[`BBO_F_ACC] && ext_set_en
        && st.ir[`BBO_F_REG] <= `BBO_IDX_LIMIT)
        |-> ea_indexed ##1 (mem_addr == $past(index_base) + {4'h0, $past(st.ir[`BBO_F_REG])});
  endproperty
  a_indexed: assert property (p_indexed) else $error("indexed mode missed");

  property p_skip;
    @(posedge clk_sys) disable iff (!reset_n)
      (st.phase == BBO_Q3 && is_skip_lo && !bit_val) |=> ##1 skip_next;
  endproperty
  a_skip: assert property (p_skip) else $error("skip missed");

  property p_set_timing;
    @(posedge clk_sys) disable iff (!reset_n)
      (st.phase == BBO_Q2 && is_set) |=> mem_rd ##1 !mem_wr ##1 mem_wr;
  endproperty
  a_set_timing: assert property (p_set_timing) else $error("set phases wrong");

  property p_skip_set;
    @(posedge clk_sys) disable iff (!reset_n)
      (st.phase == BBO_Q3 && is_skip_hi && bit_val) |=> ##1 skip_next;
  endproperty
  a_skip_set: assert property (p_skip_set) else $error("skip on set bit missed");

  property p_no_skip;
    @(posedge clk_sys) disable iff (!reset_n)
      (st.phase == BBO_Q3 && !(is_skip_lo && !bit_val) && !(is_skip_hi && bit_val))
        |=> ##1 !skip_next;
  endproperty
  a_no_skip: assert property (p_no_skip) else $error("false skip");

  property p_pc_step;
    @(posedge clk_sys) disable iff (!reset_n)
      (st.phase == BBO_Q1) |=> pc == $past(pc) + `BBO_PC_STEP;
  endproperty
  a_pc_step: assert property (p_pc_step) else $error("pc not advanced");

  property p_refill_idle;
    @(posedge clk_sys) disable iff (!reset_n)
      (st.phase == BBO_Q4 && st.refill) |=> !flush && !skip_next && !st.refill;
  endproperty
  a_refill_idle: assert property (p_refill_idle) else $error("refill cycle not idle");
endmodule

// File: sim/bbo_exec_bench.sv
// Self-checking bench for the branch and bit-op executor
module bbo_exec_bench import bbo_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic             clk_sys = 1'b0;
  logic             reset_n = 1'b0;
  logic [15:0]      instr_word = 16'h0000;
  logic [3:0]       bank_select_reg = 4'h0;
  logic             ext_set_en = 1'b0;
  logic [11:0]      index_base = 12'h000;
  logic [7:0]       mem_rdata = 8'h00;
  bbo_phase_e       phase;
  bbo_pc_t          pc;
  bbo_addr_t        mem_addr;
  logic             mem_rd;
  logic             mem_wr;
  logic [7:0]       mem_wdata;
  logic             skip_next;
  logic             flush;
  int               err_count = 0;
  int               comparisons = 0;
  integer           seed = 43;
  logic [22:0]      notes[$];
  logic             skip_pend = 1'b0;
  logic             skip_val = 1'b0;
  logic             refill = 1'b0;
  logic             primed = 1'b0;
  bbo_exec u_bbo_exec (.clk_sys(clk_sys), .reset_n(reset_n), .instr_word(instr_word),
    .bank_select_reg(bank_select_reg), .ext_set_en(ext_set_en), .index_base(index_base),
    .mem_rdata(mem_rdata), .phase(phase), .pc(pc), .mem_addr(mem_addr), .mem_rd(mem_rd),
    .mem_wr(mem_wr), .mem_wdata(mem_wdata), .skip_next(skip_next), .flush(flush));
  always #20 clk_sys = ~clk_sys;
  task automatic results;
    $display("counts: %0d comparisons, %0d mismatches", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic take(input logic [1:0] kind, input logic [20:0] got, input string what);
    logic [22:0] n;
    comparisons++;
    if (notes.size() == 0 || notes[0][22:21] !== kind) begin
      err_count++;
      $display("wrong value %s expected none seen %h", what, got);
    end else begin
      n = notes.pop_front();
      if (got !== n[20:0]) begin
        err_count++;
        $display("wrong value %s expected %h seen %h", what, n[20:0], got);
      end
    end
  endtask
  // Any stray strobe during a refill cycle finds no note and counts as a mismatch
  always @(negedge clk_sys) if (reset_n) begin
    if (mem_rd === 1'b1) take(2'd0, {9'h0, mem_addr}, "mem_addr");
    if (mem_wr === 1'b1) take(2'd1, {13'h0, mem_wdata}, "mem_wdata");
    if (flush === 1'b1) take(2'd2, pc, "pc");
    // Skip flag stands only in the first phase after the test; a stray one has no note
    if (phase === BBO_Q1
        && (skip_next !== 1'b0 || (notes.size() > 0 && notes[0][22:21] == 2'd3)))
      take(2'd3, {20'h0, skip_next}, "skip_next");
  end
  function automatic bbo_addr_t exp_addr(logic [15:0] w, logic [3:0] bs, logic ex,
                                         logic [11:0] ib);
    if (w[8]) return {bs, w[7:0]};
    if (ex && w[7:0] <= 8'h5f) return ib + {4'h0, w[7:0]};
    return {(w[7:0] < 8'h60) ? 4'h0 : 4'hf, w[7:0]};
  endfunction
  task automatic run(input logic [15:0] w);
    bbo_pc_t     at;
    logic [7:0]  rd;
    logic [3:0]  bs;
    logic        ex;
    logic [11:0] ib;
    logic [10:0] n;
    int          k;
    rd = 8'($random(seed));
    bs = 4'($random(seed));
    ex = 1'($random(seed));
    ib = 12'($random(seed));
    k = 0;
    do begin @(negedge clk_sys); k++; end while (phase !== BBO_Q4 && k < 8);
    if (k >= 8) begin err_count++; results(); end
    if (primed) comparisons++;
    if (primed && k != 4) begin
      err_count++;
      $display("wrong value phase_gap expected 4 seen %0d", k);
    end
    primed = 1'b1;
    at = pc;
    @(posedge clk_sys);
    instr_word <= w;
    mem_rdata <= rd;
    bank_select_reg <= bs;
    ext_set_en <= ex;
    index_base <= ib;
    if (skip_pend) notes.push_back({2'd3, 20'h0, skip_val});
    skip_pend = 1'b0;
    if (refill) begin refill = 1'b0; return; end
    if (w[15:12] == 4'h8 || w[15:13] == 3'b101)
      notes.push_back({2'd0, 9'h0, exp_addr(w, bs, ex, ib)});
    if (w[15:12] == 4'h8) notes.push_back({2'd1, 13'h0, rd | (8'h01 << w[11:9])});
    if (w[15:13] == 3'b101) begin
      skip_pend = 1'b1;
      skip_val = (rd[w[11:9]] == (w[15:12] == 4'ha));
    end
    if (w[15:11] == 5'h1a) begin
      n = w[10:0];
      notes.push_back({2'd2, at + 21'h2 + {{9{n[10]}}, n, 1'b0}});
      refill = 1'b1;
    end
  endtask
  initial begin
    logic [3:0]  ops[3];
    logic [7:0]  f;
    logic [10:0] offs[6];
    int          i;
    ops = '{4'h8, 4'ha, 4'hb};
    offs = '{11'h400, 11'h3ff, 11'h001, 11'h7ff, 11'h000, 11'h2a5};
    repeat (8) @(posedge clk_sys);
    reset_n <= 1'b1;
    // Access-bank split and indexed limit are hit on both sides each round
    for (i = 0; i < 36; i++) begin
      f = (i % 4 == 0) ? 8'h5f : (i % 4 == 1) ? 8'h60 : 8'($random(seed));
      run({ops[i % 3], 3'($random(seed)), 1'($random(seed)), f});
    end
    $display("bit set and bit test done");
    for (i = 0; i < 6; i++) begin
      run({5'h1a, offs[i]});
      run({4'h8, 3'($random(seed)), 1'b1, 8'($random(seed))});
    end
    $display("relative jump done");
    run(16'h0000);
    repeat (8) @(posedge clk_sys);
    comparisons++;
    if (notes.size() != 0) begin
      err_count++;
      $display("wrong value pending notes expected 0 seen %0d", notes.size());
    end
    results();
  end
endmodule
